// >>> src/rx_out_defs.svh
/*
  Constants of the receiver output control block: register offsets,
  status field positions, reset values and timing counts.
  Assumes inclusion by bare name from the package and the design modules.
*/
`ifndef RX_OUT_DEFS_SVH
`define RX_OUT_DEFS_SVH

// ****************************************************************
// widths
// ****************************************************************
`define PIX_W 24
`define CTL_W 3
`define APB_AW 8
`define TIMEOUT_W 16

// ****************************************************************
// register map
// ****************************************************************
`define REG_TIMEOUT_OFS 8'h00
`define REG_STATUS_OFS 8'h04
`define STAT_ALIVE_BIT 0
`define STAT_CHIP_DN_BIT 1
`define STAT_OUT_DN_BIT 2
`define STAT_TWO_PIX_BIT 3
`define STAT_INV_BIT 4
`define STAT_STAG_BIT 5

// ****************************************************************
// timing
// ****************************************************************
`define MCLK_PERIOD_NS 50
`define LINK_TIMEOUT_NS 1000000
`define LINK_TIMEOUT_CYC ((`LINK_TIMEOUT_NS + `MCLK_PERIOD_NS - 1) / `MCLK_PERIOD_NS)

`endif

// >>> src/rx_out_pkg.sv
/*
  Types of the receiver output control block: carrier structs for
  pixels, video control and straps, link state, and the state records
  of each clock domain.
  Assumes rx_out_defs.svh is on the include path.
*/
`include "rx_out_defs.svh"

package rx_out_pkg;

  // ****************************************************************
  // carriers
  // ****************************************************************
  typedef struct packed {
    logic [`PIX_W-1:0] even;
    logic [`PIX_W-1:0] odd;
  } pixel_pair_s;

  typedef struct packed {
    logic active;
    logic hsync;
    logic vsync;
    logic [`CTL_W-1:0] ctl;
  } video_ctrl_s;

  typedef struct packed {
    logic invert;
    logic two_pix;
    logic stag_dis;
    logic out_pwr_dn_n;
    logic chip_pwr_dn_n;
  } strap_s;

  typedef enum logic {LINK_DOWN, LINK_UP} link_state_e;

  // ****************************************************************
  // domain state records
  // ****************************************************************
  typedef struct packed {
    strap_s s1;
    strap_s s2;
    pixel_pair_s pix;
    video_ctrl_s vid;
  } pix_state_s;

  typedef struct packed {
    strap_s s1;
    strap_s s2;
    logic out_oe;
    logic general_ctrl_out_1_oe;
    logic [`TIMEOUT_W-1:0] timeout;
    logic [31:0] prdata;
    logic pslverr;
  } bus_state_s;

  typedef struct packed {
    logic de_s1;
    logic de_s2;
    logic de_prev;
    logic [`TIMEOUT_W-1:0] cnt;
    link_state_e state;
  } detect_state_s;

endpackage

// >>> src/link_alive_detect.sv
/*
  Link-alive detector: watches the data-enable level from the pixel
  domain and reports the link alive while it keeps toggling.
  Assumes a free-running clk; de_async comes from another clock domain.
*/
module link_alive_detect
  import rx_out_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic de_async,
  input wire logic enable,
  input wire logic [`TIMEOUT_W-1:0] timeout,
  output logic alive
);

  detect_state_s r_reg;
  detect_state_s r_next;
  logic edge_seen;

  assign edge_seen = r_reg.de_s2 ^ r_reg.de_prev;
  assign alive = (r_reg.state == LINK_UP);

  // ****************************************************************
  // toggle watch
  // ****************************************************************
  // counted on the free clock: the pixel clock may stop with the link
  always_comb begin
    r_next = r_reg;
    r_next.de_s1 = de_async;
    r_next.de_s2 = r_reg.de_s1;
    r_next.de_prev = r_reg.de_s2;
    if (!enable) begin
      r_next.cnt = '0;
      r_next.state = LINK_DOWN;
    end else if (edge_seen) begin
      r_next.cnt = '0;
      r_next.state = LINK_UP;
    end else if (r_reg.cnt >= timeout) begin
      r_next.state = LINK_DOWN;
    end else begin
      r_next.cnt = `TIMEOUT_W'(r_reg.cnt + 1'b1);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      r_reg <= '0;
    end else begin
      r_reg <= r_next;
    end
  end

  // ****************************************************************
  // checks
  // ****************************************************************
  chk_alive_on_toggle: assert property (
    @(posedge clk) disable iff (!rst_n)
    (enable && edge_seen) |=> alive)
    else $error("link not alive after a data-enable toggle");

  chk_down_on_timeout: assert property (
    @(posedge clk) disable iff (!rst_n)
    (enable && !edge_seen && r_reg.cnt >= timeout) |=> !alive)
    else $error("link still alive after timeout");

endmodule

// >>> src/rx_pixel_output_control.sv
/*
  Output side of a display link receiver: launches recovered pixels on
  the even and odd buses with an optionally inverted output clock,
  staggers the odd bus, reports link alive, handles both power-downs,
  and offers a small register file over APB.
  Assumes pixel inputs are synchronous to PCLK_LINK, straps are static
  pins, output pads hold weak pull-downs, and MCLK runs freely.
*/
`include "rx_out_defs.svh"

module rx_pixel_output_control
  import rx_out_pkg::*;
#(
  parameter logic [`TIMEOUT_W-1:0] LINK_TIMEOUT_CYC = `TIMEOUT_W'(`LINK_TIMEOUT_CYC)
)
(
  input wire logic MCLK,
  input wire logic RST_N,
  input wire logic PCLK_LINK,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [`APB_AW-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [`PIX_W-1:0] RX_EVEN_PIX,
  input wire logic [`PIX_W-1:0] RX_ODD_PIX,
  input wire logic RX_ACTIVE_VIDEO,
  input wire logic RX_HSYNC,
  input wire logic RX_VSYNC,
  input wire logic [`CTL_W-1:0] RX_CTL,
  input wire logic OUT_CLK_INVERT_STRAP,
  input wire logic PIXELS_PER_CLK_SELECT,
  input wire logic STAGGER_DISABLE_STRAP,
  input wire logic OUT_POWER_DOWN_N,
  input wire logic CHIP_POWER_DOWN_N,
  output logic PIXEL_OUT_CLK,
  output logic [`PIX_W-1:0] EVEN_PIXEL_BUS,
  output logic [`PIX_W-1:0] ODD_PIXEL_BUS,
  output logic ACTIVE_VIDEO_FLAG,
  output logic HSYNC_OUT,
  output logic VSYNC_OUT,
  output logic GENERAL_CTRL_OUT_1,
  output logic GENERAL_CTRL_OUT_2,
  output logic GENERAL_CTRL_OUT_3,
  output logic OUT_OE,
  output logic GENERAL_CTRL_OUT_1_OE,
  output logic LINK_ALIVE
);

  // ****************************************************************
  // declarations
  // ****************************************************************
  strap_s strap_pins;
  pix_state_s p_reg;
  pix_state_s p_next;
  bus_state_s b_reg;
  bus_state_s b_next;
  logic [1:0] prst_sync;
  logic prst_n;
  logic [`PIX_W-1:0] odd_late_reg;
  logic stagger_on;
  logic bus_setup;
  logic bus_wr;
  logic alive;

  assign strap_pins = '{
    invert: OUT_CLK_INVERT_STRAP,
    two_pix: PIXELS_PER_CLK_SELECT,
    stag_dis: STAGGER_DISABLE_STRAP,
    out_pwr_dn_n: OUT_POWER_DOWN_N,
    chip_pwr_dn_n: CHIP_POWER_DOWN_N
  };

  // ****************************************************************
  // pixel domain reset release
  // ****************************************************************
  // assert at once, release on the pixel clock
  always_ff @(posedge PCLK_LINK or negedge RST_N) begin
    if (!RST_N) begin
      prst_sync <= 2'h0;
    end else begin
      prst_sync <= {prst_sync[0], 1'b1};
    end
  end

  assign prst_n = prst_sync[1];

  // ****************************************************************
  // pixel domain: strap sync and output launch
  // ****************************************************************
  always_comb begin
    p_next = p_reg;
    p_next.s1 = strap_pins;
    p_next.s2 = p_reg.s1;
    if (!p_reg.s2.chip_pwr_dn_n) begin
      // inputs ignored, every output brought low
      p_next.pix = '0;
      p_next.vid = '0;
    end else begin
      // output power-down does not stop the pipeline
      p_next.pix.even = RX_EVEN_PIX;
      p_next.pix.odd = p_reg.s2.two_pix ? RX_ODD_PIX : '0;
      p_next.vid = '{
        active: RX_ACTIVE_VIDEO,
        hsync: RX_HSYNC,
        vsync: RX_VSYNC,
        ctl: RX_CTL
      };
    end
  end

  always_ff @(posedge PCLK_LINK or negedge prst_n) begin
    if (!prst_n) begin
      p_reg <= '0;
    end else begin
      p_reg <= p_next;
    end
  end

  // ****************************************************************
  // staggered odd bus
  // ****************************************************************
  // relaunched on the falling edge, half a period behind the even bus
  always_ff @(negedge PCLK_LINK or negedge prst_n) begin
    if (!prst_n) begin
      odd_late_reg <= '0;
    end else begin
      odd_late_reg <= p_reg.pix.odd;
    end
  end

  assign stagger_on = p_reg.s2.two_pix & ~p_reg.s2.stag_dis;

  // ****************************************************************
  // pin outputs
  // ****************************************************************
  // polarity only flips the clock; data paths never see the strap
  // strap changes may glitch the clock once; straps are meant static
  assign PIXEL_OUT_CLK = p_reg.s2.chip_pwr_dn_n & (PCLK_LINK ^ p_reg.s2.invert);
  assign EVEN_PIXEL_BUS = p_reg.pix.even;
  assign ODD_PIXEL_BUS = stagger_on ? odd_late_reg : p_reg.pix.odd;
  assign ACTIVE_VIDEO_FLAG = p_reg.vid.active;
  assign HSYNC_OUT = p_reg.vid.hsync;
  assign VSYNC_OUT = p_reg.vid.vsync;
  assign GENERAL_CTRL_OUT_1 = p_reg.vid.ctl[0];
  assign GENERAL_CTRL_OUT_2 = p_reg.vid.ctl[1];
  assign GENERAL_CTRL_OUT_3 = p_reg.vid.ctl[2];

  // enables on the free clock so a stopped link still tri-states
  assign OUT_OE = b_reg.out_oe;
  assign GENERAL_CTRL_OUT_1_OE = b_reg.general_ctrl_out_1_oe;
  assign LINK_ALIVE = alive;

  // ****************************************************************
  // bus domain: strap sync, enables and registers
  // ****************************************************************
  assign bus_setup = PSEL & ~PENABLE;
  assign bus_wr = PSEL & PENABLE & PWRITE;

  always_comb begin
    b_next = b_reg;
    b_next.s1 = strap_pins;
    b_next.s2 = b_reg.s1;
    b_next.out_oe = b_reg.s2.chip_pwr_dn_n & b_reg.s2.out_pwr_dn_n;
    b_next.general_ctrl_out_1_oe = b_reg.s2.chip_pwr_dn_n;
    if (bus_setup) begin
      b_next.prdata = '0;
      b_next.pslverr = 1'b0;
      unique case (PADDR)
        `REG_TIMEOUT_OFS: begin
          b_next.prdata[`TIMEOUT_W-1:0] = PWRITE ? '0 : b_reg.timeout;
        end
        `REG_STATUS_OFS: begin
          if (!PWRITE) begin
            b_next.prdata[`STAT_ALIVE_BIT] = alive;
            b_next.prdata[`STAT_CHIP_DN_BIT] = b_reg.s2.chip_pwr_dn_n;
            b_next.prdata[`STAT_OUT_DN_BIT] = b_reg.s2.out_pwr_dn_n;
            b_next.prdata[`STAT_TWO_PIX_BIT] = b_reg.s2.two_pix;
            b_next.prdata[`STAT_INV_BIT] = b_reg.s2.invert;
            b_next.prdata[`STAT_STAG_BIT] = b_reg.s2.stag_dis;
          end
        end
        default: begin
          b_next.pslverr = 1'b1;
        end
      endcase
    end
    if (bus_wr && PADDR == `REG_TIMEOUT_OFS) begin
      b_next.timeout = PWDATA[`TIMEOUT_W-1:0];
    end
  end

  always_ff @(posedge MCLK or negedge RST_N) begin
    if (!RST_N) begin
      b_reg <= '0;
      b_reg.timeout <= LINK_TIMEOUT_CYC;
    end else begin
      b_reg <= b_next;
    end
  end

  assign PREADY = 1'b1;
  assign PRDATA = b_reg.prdata;
  assign PSLVERR = PSEL & PENABLE & b_reg.pslverr;

  // ****************************************************************
  // link alive detector
  // ****************************************************************
  link_alive_detect u_alive (
    .clk(MCLK),
    .rst_n(RST_N),
    .de_async(p_reg.vid.active),
    .enable(b_reg.s2.chip_pwr_dn_n),
    .timeout(b_reg.timeout),
    .alive(alive)
  );

  // ****************************************************************
  // checks: pixel domain
  // ****************************************************************
  chk_even_launch: assert property (
    @(posedge PCLK_LINK) disable iff (!prst_n)
    p_reg.s2.chip_pwr_dn_n |=> EVEN_PIXEL_BUS == $past(RX_EVEN_PIX))
    else $error("even bus did not carry the input pixel");

  chk_odd_launch: assert property (
    @(posedge PCLK_LINK) disable iff (!prst_n)
    (p_reg.s2.chip_pwr_dn_n && p_reg.s2.two_pix) |=> p_reg.pix.odd == $past(RX_ODD_PIX))
    else $error("odd pixel not launched in two-pixel mode");

  chk_odd_single_low: assert property (
    @(posedge PCLK_LINK) disable iff (!prst_n)
    (!p_reg.s2.two_pix ##1 !p_reg.s2.two_pix) |-> ODD_PIXEL_BUS == '0)
    else $error("odd bus not low in one-pixel mode");

  chk_de_aligned: assert property (
    @(posedge PCLK_LINK) disable iff (!prst_n)
    p_reg.s2.chip_pwr_dn_n |=> ACTIVE_VIDEO_FLAG == $past(RX_ACTIVE_VIDEO))
    else $error("data-enable not aligned with pixel data");

  chk_out_dn_running: assert property (
    @(posedge PCLK_LINK) disable iff (!prst_n)
    (p_reg.s2.chip_pwr_dn_n && !p_reg.s2.out_pwr_dn_n)
      |=> p_reg.pix.even == $past(RX_EVEN_PIX))
    else $error("pipeline stopped under output power-down");

  chk_chip_dn_low: assert property (
    @(posedge PCLK_LINK) disable iff (!prst_n)
    !p_reg.s2.chip_pwr_dn_n |=> (EVEN_PIXEL_BUS == '0 && p_reg.pix.odd == '0
      && !ACTIVE_VIDEO_FLAG && !GENERAL_CTRL_OUT_1))
    else $error("outputs not low in chip power-down");

  chk_stagger_plain: assert property (
    @(posedge PCLK_LINK) disable iff (!prst_n)
    (!p_reg.s2.two_pix || p_reg.s2.stag_dis) |-> ODD_PIXEL_BUS == p_reg.pix.odd)
    else $error("odd bus staggered outside two-pixel stagger mode");

  chk_stagger_late: assert property (
    @(negedge PCLK_LINK) disable iff (!prst_n)
    (stagger_on ##1 stagger_on) |-> ODD_PIXEL_BUS == $past(p_reg.pix.odd))
    else $error("staggered odd bus not half a period late");

  // ****************************************************************
  // checks: bus domain
  // ****************************************************************
  chk_oe_follow_pins: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    1'b1 |=> (OUT_OE == $past(b_reg.s2.chip_pwr_dn_n && b_reg.s2.out_pwr_dn_n)
      && GENERAL_CTRL_OUT_1_OE == $past(b_reg.s2.chip_pwr_dn_n)))
    else $error("output enables do not follow power-down pins");

  chk_alive_dn_low: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (!b_reg.s2.chip_pwr_dn_n ##1 !b_reg.s2.chip_pwr_dn_n) |-> !LINK_ALIVE)
    else $error("link alive high in chip power-down");

  chk_timeout_write: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (bus_wr && PADDR == `REG_TIMEOUT_OFS)
      |=> b_reg.timeout == $past(PWDATA[`TIMEOUT_W-1:0]))
    else $error("timeout register not written");

  chk_unmapped_err: assert property (
    @(posedge MCLK) disable iff (!RST_N)
    (bus_setup && PADDR != `REG_TIMEOUT_OFS && PADDR != `REG_STATUS_OFS)
      |=> (PSEL && PENABLE) |-> PSLVERR)
    else $error("unmapped access not answered with an error");

endmodule

// >>> tb/panel_sink.sv
/*
  Panel-side model: resolves the receiver output pins with their weak
  pull-downs and counts active lines seen at the panel.
  Assumes oe_in high while the receiver drives the pins.
*/
`include "rx_out_defs.svh"

module panel_sink
  import rx_out_pkg::*;
(
  input wire logic pix_clk,
  input wire logic oe_in,
  input wire logic [`PIX_W-1:0] even_in,
  input wire logic de_in,
  output logic [`PIX_W-1:0] even_pin,
  output logic de_pin,
  output int line_count
);
  timeunit 1ns;
  timeprecision 1ps;
  logic de_last = 1'h0;
  int cnt = 0;

  assign line_count = cnt;

  // ****************************************************************
  // pins and line counter
  // ****************************************************************
  // released pins fall to ground
  assign even_pin = oe_in ? even_in : '0;
  assign de_pin = oe_in ? de_in : 1'h0;

  always @(posedge pix_clk) begin
    if (de_pin && !de_last) cnt <= cnt + 1;
    de_last <= de_pin;
  end
endmodule

// >>> tb/testbench.sv
/*
  Self-checking bench of the receiver output control block: random pixel
  stream, every combination of the invert, pixel-count and stagger straps, both power-downs and link alive.
  Assumes the design package and panel_sink are compiled first.
*/
`include "rx_out_defs.svh"

module testbench
  import rx_out_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TMO = 40;
  logic mclk = 1'h0;
  logic pclk = 1'h0;
  logic rst_n = 1'h0;
  logic psel = 1'h0;
  logic penable = 1'h0;
  logic pwrite = 1'h0;
  logic [7:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  pixel_pair_s rx_pix = '0;
  video_ctrl_s rx_vid = '0;
  strap_s st = 5'h07;
  logic oclk, de_o, hs_o, vs_o, c1, c2, c3, oe, c1_oe, alive, de_pin;
  logic [`PIX_W-1:0] ev, od, ev_pin;
  int lines;
  pixel_pair_s p1 = '0, p2 = '0, p3 = '0;
  video_ctrl_s v1 = '0, v2 = '0;
  int fail_count = 0;
  int total_checks = 0;
  integer seed = 32'h319E1B2A;
  logic chk_on = 1'h0;
  logic de_hold = 1'h0;
  logic [31:0] r;
  logic [31:0] rnd;
  logic e;

  always #25 mclk = ~mclk;
  always begin
    if ($time == 0) #13;
    #80 pclk = ~pclk;
  end

  rx_pixel_output_control #(.LINK_TIMEOUT_CYC(`TIMEOUT_W'(TMO))) dut_u (.MCLK(mclk),
    .RST_N(rst_n), .PCLK_LINK(pclk), .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite),
    .PADDR(paddr), .PWDATA(pwdata), .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr),
    .RX_EVEN_PIX(rx_pix.even), .RX_ODD_PIX(rx_pix.odd), .RX_ACTIVE_VIDEO(rx_vid.active),
    .RX_HSYNC(rx_vid.hsync), .RX_VSYNC(rx_vid.vsync), .RX_CTL(rx_vid.ctl),
    .OUT_CLK_INVERT_STRAP(st.invert), .PIXELS_PER_CLK_SELECT(st.two_pix),
    .STAGGER_DISABLE_STRAP(st.stag_dis), .OUT_POWER_DOWN_N(st.out_pwr_dn_n),
    .CHIP_POWER_DOWN_N(st.chip_pwr_dn_n), .PIXEL_OUT_CLK(oclk), .EVEN_PIXEL_BUS(ev),
    .ODD_PIXEL_BUS(od), .ACTIVE_VIDEO_FLAG(de_o), .HSYNC_OUT(hs_o), .VSYNC_OUT(vs_o),
    .GENERAL_CTRL_OUT_1(c1), .GENERAL_CTRL_OUT_2(c2), .GENERAL_CTRL_OUT_3(c3),
    .OUT_OE(oe), .GENERAL_CTRL_OUT_1_OE(c1_oe), .LINK_ALIVE(alive));

  panel_sink sink_u (.pix_clk(oclk), .oe_in(oe), .even_in(ev), .de_in(de_o),
    .even_pin(ev_pin), .de_pin(de_pin), .line_count(lines));

  // ****************************************************************
  // expectations, compare and closing
  // ****************************************************************
  function automatic logic [31:0] odd_exp(input logic pixels_per_clk_select, input logic [31:0] d);
    return pixels_per_clk_select ? d : '0;
  endfunction

  function automatic logic [31:0] status_exp(input logic a, input strap_s s);
    return {26'h0, s.stag_dis, s.invert, s.two_pix, s.out_pwr_dn_n, s.chip_pwr_dn_n, a};
  endfunction

  task cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    total_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("[FAIL] %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask

  task give_up();
    fail_count++;
    $display("[FAIL] %0t wait ran out", $time);
    tally_and_finish();
  endtask

  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge mclk);
    psel <= 1'h1;
    penable <= 1'h0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'h1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'h1 && n < 16);
    if (pready !== 1'h1) give_up();
    r = prdata;
    e = pslverr;
    psel <= 1'h0;
    penable <= 1'h0;
  endtask

  task wait_alive(input logic v, input int n);
    for (int i = 0; i < n && alive !== v; i++) @(posedge mclk);
    if (alive !== v) give_up();
  endtask

  // ****************************************************************
  // pixel stream and its checks
  // ****************************************************************
  always @(posedge pclk) begin
    if (chk_on) begin
      cmp(ev, p2.even, "even");
      cmp(od, odd_exp(st.two_pix, p2.odd), "odd");
      cmp(de_o, v2.active, "active flag");
      cmp({hs_o, vs_o}, {v2.hsync, v2.vsync}, "sync");
      cmp({c3, c2, c1}, v2.ctl, "control outputs");
    end
    p3 = p2;
    p2 = p1;
    v2 = v1;
    rnd = $random(seed);
    p1.even = rnd[23:0];
    rnd = $random(seed);
    p1.odd = rnd[23:0];
    v1 = video_ctrl_s'(rnd[29:24]);
    if (de_hold) v1.active = 1'h0;
    rx_pix <= p1;
    rx_vid <= v1;
  end

  // odd bus lags half a period only when staggered in two-pixel mode
  always @(negedge pclk) begin
    if (chk_on) begin
      cmp(ev, p2.even, "even at fall");
      cmp(od, odd_exp(st.two_pix, (st.two_pix && !st.stag_dis) ? p3.odd : p2.odd),
        "odd at fall");
    end
  end

  always @(negedge mclk) begin
    if (chk_on) cmp(oclk, pclk ^ st.invert, "output clock");
  end

  // ****************************************************************
  // main sequence
  // ****************************************************************
  initial begin
    repeat (3) @(posedge mclk);
    rst_n <= 1'h1;
    repeat (20) @(posedge mclk);
    chk_on = 1'h1;
    apb(1'h0, `REG_TIMEOUT_OFS, '0);
    cmp(r, 32'(TMO), "timeout reset");
    apb(1'h1, `REG_TIMEOUT_OFS, {16'hABCD, 16'(TMO - 4)});
    apb(1'h0, `REG_TIMEOUT_OFS, '0);
    cmp({e, r}, {1'h0, 32'(TMO - 4)}, "timeout readback");
    apb(1'h1, `REG_STATUS_OFS, 32'hFFFFFFFF);
    apb(1'h0, 8'h08, '0);
    cmp({e, r}, {1'h1, 32'h0}, "unmapped read");
    for (int i = 0; i < 8; i++) begin
      @(posedge mclk);
      chk_on = 1'h0;
      st.invert <= i[0];
      st.two_pix <= i[1];
      st.stag_dis <= i[2];
      repeat (20) @(posedge mclk);
      chk_on = 1'h1;
      repeat (60) @(posedge mclk);
      apb(1'h0, `REG_STATUS_OFS, '0);
      cmp({e, r}, {1'h0, status_exp(1'h1, st)}, "status");
    end
    st.out_pwr_dn_n <= 1'h0;
    repeat (10) @(posedge mclk);
    cmp({oe, c1_oe, alive}, 3'h3, "output power-down");
    cmp({ev_pin, de_pin}, '0, "pins pulled down");
    repeat (40) @(posedge mclk);
    apb(1'h0, `REG_STATUS_OFS, '0);
    cmp(r, status_exp(1'h1, st), "status in output power-down");
    st.out_pwr_dn_n <= 1'h1;
    repeat (10) @(posedge mclk);
    cmp(oe, 1'h1, "outputs back");
    de_hold = 1'h1;
    repeat (30) @(posedge mclk);
    cmp(alive, 1'h1, "alive before timeout");
    wait_alive(1'h0, 30);
    cmp(lines > 0, 1'h1, "lines seen");
    de_hold = 1'h0;
    wait_alive(1'h1, 40);
    chk_on = 1'h0;
    st.chip_pwr_dn_n <= 1'h0;
    repeat (20) @(posedge mclk);
    cmp({oe, c1_oe, alive, oclk, de_o, ev}, '0, "chip power-down");
    st.chip_pwr_dn_n <= 1'h1;
    wait_alive(1'h1, 80);
    cmp({oe, c1_oe}, 2'h3, "power-up");
    tally_and_finish();
  end

  initial begin
    repeat (100000) @(posedge mclk);
    give_up();
  end
endmodule
